// File: rtl/spidr_pkg.sv
// package: register map, field positions, states and state record of the serial port control
//
// Behaviour
// - system reset returns data registers, control bits and flags to defaults
// - a low port enable holds the port in partial reset
// - tx empty flag is forced set while the port is disabled
// - disabling during a slave transfer aborts it at once
// - disabling during a master transfer lets it finish first
// - while disabled the bit counter is cleared for a fresh transfer
// - pin drivers turn off and counter clears after abort or completion
// - transmit and receive data registers survive a disable
// - control and size bits survive a disable; system reset clears control bits and sets size to 7
// - rx full, overrun and select fault flags survive a disable
// - writing zero disables; a master select fault also clears enable
// - tx request when tx irq enable, port enable, and empty or tx watermark
// - tx empty sets when a word moves to the shifter with none pending
// - tx empty clears only by writing the transmit data register
// - rx request when rx irq enable, port enable, and full or rx watermark
// - rx full sets when a word lands in the receive register
// - rx full clears when software reads the receive data register
// - one error enable routes overrun and select fault to the error request
// - select fault sets only while select fault enable is set
// - select fault raises the error request even while disabled
// - overrun clears by status read followed by receive data read
// - select fault clears by writing one to its status bit
package spidr_pkg;
    // byte offsets on the register bus, decoded on address bits 3:2
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_SIZE = 4'h4;
    localparam logic [3:0] OFS_TXD = 4'h8;
    localparam logic [3:0] OFS_RXD = 4'hC;
    // control and status register fields
    localparam int B_EN = 0;
    localparam int B_MSTR = 1;
    localparam int B_SFEN = 2;
    localparam int B_TIE = 3;
    localparam int B_RIE = 4;
    localparam int B_EIE = 5;
    localparam int B_TXE = 8;
    localparam int B_RXF = 9;
    localparam int B_OVR = 10;
    localparam int B_SF = 11;
    localparam int B_BUSY = 12;
    // word length minus one
    localparam logic [4:0] SIZE_RST = 5'h07;
    localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;
    localparam logic [4:0] MSB_IDX = 5'h1F;
    localparam logic [5:0] CNT_ONE = 6'h01;
    localparam logic [7:0] DIV_ONE = 8'h01;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_XFER = 2'b10
    } spidr_st_t;

    typedef struct packed {
        spidr_st_t st;
        logic en;
        logic mstr;
        logic sfen;
        logic tie;
        logic rie;
        logic eie;
        logic [4:0] size;
        logic [31:0] txd;
        logic [31:0] rxd;
        logic [31:0] sh;
        logic tx_empty;
        logic rx_full;
        logic ovr;
        logic sf;
        logic ovr_arm;
        logic [5:0] cnt;
        logic [7:0] div;
        logic sclk;
        logic dout;
        logic ack;
        logic [31:0] rdata;
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
    } spidr_state_t;
endpackage

// File: rtl/spidr_core.sv
// serial port control: register slave, partial reset, flags and interrupt requests
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
module spidr_core
    import spidr_pkg::*;
#(
    parameter logic [7:0] HALF_DIV = 8'h04
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic ss_n_i,
    input wire logic tx_watermark_i,
    input wire logic rx_watermark_i,
    output logic tx_irq_o,
    output logic rx_err_irq_o
);

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a[3:2] == ofs[3:2]);
    endfunction

    spidr_state_t q, d;
    logic req, fin, ctrl_wr, size_wr, txd_wr, rxd_rd, ctrl_rd;
    logic sclk_s, mosi_s, miso_s, ss_s;
    logic rise, fall, word_end, rx_set, ovr_set, sf_set, m_fault;
    logic [5:0] len;
    logic [31:0] word;

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        d = q;
        req = avs_read_i | avs_write_i;
        fin = req & q.ack;
        ctrl_wr = fin & avs_write_i & hit(avs_address_i, OFS_CTRL);
        size_wr = fin & avs_write_i & hit(avs_address_i, OFS_SIZE);
        txd_wr = fin & avs_write_i & hit(avs_address_i, OFS_TXD);
        ctrl_rd = fin & avs_read_i & hit(avs_address_i, OFS_CTRL);
        rxd_rd = fin & avs_read_i & hit(avs_address_i, OFS_RXD);

        // the second stage of each synchroniser gives the level, the third stage the previous level for edges
        d.s1 = {ss_n_i, miso_i, mosi_i, sclk_i};
        d.s2 = q.s1;
        d.s3 = q.s2;
        sclk_s = q.s2[0];
        mosi_s = q.s2[1];
        miso_s = q.s2[2];
        ss_s = q.s2[3];

        len = {1'b0, q.size} + CNT_ONE;
        word = q.sh & (ALL_ONES >> (MSB_IDX - q.size));
        rise = 1'b0;
        fall = 1'b0;
        word_end = 1'b0;
        rx_set = 1'b0;
        ovr_set = 1'b0;
        sf_set = 1'b0;
        m_fault = q.en & q.mstr & q.sfen & ~ss_s;

        // ****************************************************
        // transfer engine
        // ****************************************************
        unique case (q.st)
            ST_IDLE: begin
                d.sclk = 1'b0;
                d.cnt = '0;
                if (q.en & q.mstr & ~q.tx_empty & ~m_fault) begin
                    d.st = ST_XFER;
                    d.sh = q.txd;
                    d.tx_empty = 1'b1;
                    d.dout = q.txd[q.size];
                    d.div = HALF_DIV;
                end else if (q.en & ~q.mstr & ~ss_s & q.s3[3]) begin
                    // slave with nothing new resends the last word
                    d.st = ST_XFER;
                    d.sh = q.txd;
                    d.tx_empty = 1'b1;
                    d.dout = q.txd[q.size];
                end
            end
            ST_XFER: begin
                if (q.mstr) begin
                    if (q.div == DIV_ONE) begin
                        d.div = HALF_DIV;
                        d.sclk = ~q.sclk;
                        rise = ~q.sclk;
                        fall = q.sclk;
                    end else begin
                        d.div = q.div - DIV_ONE;
                    end
                end else begin
                    rise = sclk_s & ~q.s3[0];
                    fall = ~sclk_s & q.s3[0];
                end
                if (rise) begin
                    d.sh = {q.sh[30:0], q.mstr ? miso_s : mosi_s};
                    d.cnt = q.cnt + CNT_ONE;
                end
                // next bit leaves on the fall, so it stands a half period before sampling
                if (fall) begin
                    d.dout = q.sh[q.size];
                end
                if (fall & (q.cnt == len)) begin
                    word_end = 1'b1;
                    d.st = ST_IDLE;
                    d.cnt = '0;
                end
                if (~q.mstr & ss_s) begin
                    // slave deselected mid word: drop it
                    sf_set = q.sfen & (q.cnt != '0);
                    d.st = ST_IDLE;
                    d.cnt = '0;
                end
                if (~q.en & ~q.mstr) begin
                    d.st = ST_IDLE;
                    d.cnt = '0;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        if (word_end) begin
            // a full register or a pending overrun keeps the new word out
            if (q.rx_full | q.ovr) begin
                ovr_set = 1'b1;
            end else begin
                d.rxd = word;
                rx_set = 1'b1;
            end
        end

        // ****************************************************
        // register slave
        // ****************************************************
        d.ack = req & ~q.ack;
        if (avs_read_i & ~q.ack) begin
            d.rdata = '0;
            if (hit(avs_address_i, OFS_CTRL)) begin
                d.rdata[B_EN] = q.en;
                d.rdata[B_MSTR] = q.mstr;
                d.rdata[B_SFEN] = q.sfen;
                d.rdata[B_TIE] = q.tie;
                d.rdata[B_RIE] = q.rie;
                d.rdata[B_EIE] = q.eie;
                d.rdata[B_TXE] = q.tx_empty;
                d.rdata[B_RXF] = q.rx_full;
                d.rdata[B_OVR] = q.ovr;
                d.rdata[B_SF] = q.sf;
                d.rdata[B_BUSY] = (q.st == ST_XFER);
            end else if (hit(avs_address_i, OFS_SIZE)) begin
                d.rdata[4:0] = q.size;
            end else if (hit(avs_address_i, OFS_TXD)) begin
                d.rdata = q.txd;
            end else begin
                d.rdata = q.rxd;
            end
        end
        if (ctrl_wr) begin
            d.en = avs_writedata_i[B_EN];
            d.mstr = avs_writedata_i[B_MSTR];
            d.sfen = avs_writedata_i[B_SFEN];
            d.tie = avs_writedata_i[B_TIE];
            d.rie = avs_writedata_i[B_RIE];
            d.eie = avs_writedata_i[B_EIE];
            if (avs_writedata_i[B_SF]) begin
                d.sf = 1'b0;
            end
        end
        if (size_wr) begin
            d.size = avs_writedata_i[4:0];
        end
        if (txd_wr) begin
            d.txd = avs_writedata_i;
            d.tx_empty = 1'b0;
        end
        if (ctrl_rd & q.ovr) begin
            d.ovr_arm = 1'b1;
        end
        if (rxd_rd) begin
            d.rx_full = 1'b0;
            if (q.ovr_arm) begin
                d.ovr = 1'b0;
                d.ovr_arm = 1'b0;
            end
        end

        // hardware sets come last so an event never loses to a clear
        if (rx_set) begin
            d.rx_full = 1'b1;
        end
        if (ovr_set) begin
            d.ovr = 1'b1;
            d.ovr_arm = 1'b0;
        end
        if (sf_set | m_fault) begin
            d.sf = 1'b1;
        end
        if (m_fault) begin
            d.en = 1'b0;
        end

        // partial reset: only the transmit flag is touched, the rest is kept
        if (~d.en) begin
            d.tx_empty = 1'b1;
        end
    end

    // ********************************************************
    // state register
    // ********************************************************
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.size <= SIZE_RST;
            q.tx_empty <= 1'b1;
            q.s1 <= 4'hF;
            q.s2 <= 4'hF;
            q.s3 <= 4'hF;
        end else begin
            q <= d;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    logic active;
    // a master still finishing its word keeps driving after disable
    assign active = q.en | (q.st == ST_XFER);
    assign avs_waitrequest_o = req & ~q.ack;
    assign avs_readdata_o = q.rdata;
    assign sclk_o = q.sclk;
    assign mosi_o = q.dout;
    assign miso_o = q.dout;
    assign sclk_oe_o = active & q.mstr;
    assign mosi_oe_o = active & q.mstr;
    assign miso_oe_o = active & ~q.mstr & ~ss_s;
    assign tx_irq_o = q.tie & q.en & (q.tx_empty | tx_watermark_i);
    // the error path ignores the enable so faults stay visible when off
    assign rx_err_irq_o = (q.rie & q.en & (q.rx_full | rx_watermark_i))
        | (q.eie & (q.ovr | q.sf));

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_dis_txe;
        !q.en |-> q.tx_empty;
    endproperty
    a_dis_txe: assert property (p_dis_txe) else $error("tx empty low while disabled");

    property p_txd_clr;
        (txd_wr && q.en && !m_fault) |=> !q.tx_empty;
    endproperty
    a_txd_clr: assert property (p_txd_clr) else $error("tx data write kept empty");

    property p_rxd_clr;
        (rxd_rd && !word_end) |=> !q.rx_full;
    endproperty
    a_rxd_clr: assert property (p_rxd_clr) else $error("rx read kept full");

    property p_sf_w1c;
        (ctrl_wr && avs_writedata_i[B_SF] && !sf_set && !m_fault) |=> !q.sf;
    endproperty
    a_sf_w1c: assert property (p_sf_w1c) else $error("select fault not cleared");

    property p_mfault;
        (q.en && q.mstr && q.sfen && !ss_s) |=> (!q.en && q.sf);
    endproperty
    a_mfault: assert property (p_mfault) else $error("master fault kept enable");

    property p_slv_abort;
        (!q.en && !q.mstr && q.st == ST_XFER) |=> (q.st == ST_IDLE && q.cnt == '0);
    endproperty
    a_slv_abort: assert property (p_slv_abort) else $error("slave not aborted");

    property p_mst_run;
        (q.mstr && q.st == ST_XFER && q.cnt != len && !ctrl_wr && !size_wr)
            |=> (q.st == ST_XFER);
    endproperty
    a_mst_run: assert property (p_mst_run) else $error("master word cut short");

    property p_pins_off;
        (!q.en && q.st == ST_IDLE)
            |-> (!sclk_oe_o && !mosi_oe_o && !miso_oe_o && q.cnt == '0);
    endproperty
    a_pins_off: assert property (p_pins_off) else $error("pins driven while off");

    property p_ovr_clr;
        $fell(q.ovr) |-> ($past(q.ovr_arm) && $past(rxd_rd));
    endproperty
    a_ovr_clr: assert property (p_ovr_clr) else $error("overrun cleared early");

    property p_sf_gate;
        $rose(q.sf) |-> $past(q.sfen);
    endproperty
    a_sf_gate: assert property (p_sf_gate) else $error("fault set while gated");

    property p_sf_irq;
        (q.eie && q.sf && !q.en) [*2] |-> rx_err_irq_o;
    endproperty
    a_sf_irq: assert property (p_sf_irq) else $error("fault request lost");

    property p_rx_set;
        (word_end && !q.rx_full && !q.ovr) |=> (q.rx_full && q.rxd == $past(word));
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("received word not stored");

    property p_ovr_keep;
        (word_end && (q.rx_full || q.ovr)) |=> (q.ovr && $stable(q.rxd));
    endproperty
    a_ovr_keep: assert property (p_ovr_keep) else $error("overrun lost old word");

    property p_mst_load;
        (q.st == ST_IDLE && q.en && q.mstr && !q.tx_empty && !m_fault && !txd_wr)
            |=> (q.st == ST_XFER && q.tx_empty);
    endproperty
    a_mst_load: assert property (p_mst_load) else $error("pending word not loaded");

    property p_cnt_clr;
        (q.st == ST_IDLE) |-> (q.cnt == '0);
    endproperty
    a_cnt_clr: assert property (p_cnt_clr) else $error("bit counter left set");

    property p_dis_flags;
        (!q.en && !word_end && !rxd_rd) |=> ($stable(q.rx_full) && $stable(q.ovr));
    endproperty
    a_dis_flags: assert property (p_dis_flags) else $error("flag lost while off");

    property p_dis_data;
        (!q.en && !txd_wr && !word_end) |=> ($stable(q.txd) && $stable(q.rxd));
    endproperty
    a_dis_data: assert property (p_dis_data) else $error("data lost while off");

    property p_dis_ctrl;
        (!q.en && !ctrl_wr && !size_wr)
            |=> ($stable(q.mstr) && $stable(q.sfen) && $stable(q.size)
                && $stable(q.tie) && $stable(q.rie) && $stable(q.eie));
    endproperty
    a_dis_ctrl: assert property (p_dis_ctrl) else $error("control lost while off");

    property p_tx_off;
        !q.en |-> !tx_irq_o;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("tx request while off");

    property p_rx_off;
        (!q.en && !q.eie) |-> !rx_err_irq_o;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx request while off");

    property p_err_req;
        (q.eie && q.ovr) |-> rx_err_irq_o;
    endproperty
    a_err_req: assert property (p_err_req) else $error("overrun request lost");

    c_mst_word: cover property (q.mstr && word_end && rx_set);
    c_slv_abort: cover property (!q.en && !q.mstr && q.st == ST_XFER);
    c_overrun: cover property (ovr_set);
    c_mfault: cover property (m_fault);
    c_slv_word: cover property (!q.mstr && word_end);

endmodule // spidr_core

// File: verification/spidr_far.sv
// partner: external serial device, slave to a master port and master to a slave port
`timescale 1ns/10ps
module spidr_far (
    input wire logic clk_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    output logic miso_o,
    output logic sclk_o,
    output logic mosi_o,
    output logic ss_n_o
);
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [7:0] got_q;
    initial begin
        tx_q = 8'h00;
        rx_q = 8'h00;
        got_q = 8'h00;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        ss_n_o = 1'b1;
    end
    assign miso_o = tx_q[7];
    // inverse bits refill the shifter, so stale data never looks valid
    always @(negedge sclk_i) tx_q <= {tx_q[6:0], ~tx_q[7]};
    always @(posedge sclk_i) rx_q <= {rx_q[6:0], mosi_i};
    // as master the model captures the port's slave output on its own rising clock
    always @(posedge sclk_o) got_q <= {got_q[6:0], miso_i};
    task automatic load(input logic [7:0] w);
        tx_q = w;
    endtask
    task automatic sel(input logic v);
        @(posedge clk_i);
        ss_n_o <= v;
        repeat (16) @(posedge clk_i);
    endtask
    // clock stands low between frames; 16 cycles per half period
    task automatic shift(input logic [7:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            mosi_o <= w[7 - i];
            repeat (16) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (16) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        repeat (16) @(posedge clk_i);
        mosi_o <= ~mosi_o;
    endtask
endmodule // spidr_far

// File: verification/spi_disable_reset_and_irq_tb.sv
// bench: register bus, partial reset, flags and requests of the serial port
`timescale 1ns/10ps
module spi_disable_reset_and_irq_tb;
    import spidr_pkg::*;
    logic clk = 1'b0;
    logic rst;
    logic [3:0] adr;
    logic rd_s;
    logic wr_s;
    logic [31:0] wd;
    logic txw;
    logic rxw;
    logic [31:0] rdo;
    logic wrq, sck_o, sck_oe, mo_o, mo_oe, mi_o, mi_oe, txi, rxi;
    logic p_sck, p_mo, p_mi, p_ss_n, sck_w, mo_w, mi_w;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 32'hD08B;
    always #2.5 clk = ~clk;
    assign sck_w = sck_oe ? sck_o : p_sck;
    assign mo_w = mo_oe ? mo_o : p_mo;
    assign mi_w = mi_oe ? mi_o : p_mi;
    spidr_core #(.HALF_DIV(8'h04)) uut (
        .core_clk_i(clk), .sys_rst_i(rst), .avs_address_i(adr),
        .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd),
        .avs_readdata_o(rdo), .avs_waitrequest_o(wrq),
        .sclk_i(sck_w), .sclk_o(sck_o), .sclk_oe_o(sck_oe),
        .mosi_i(mo_w), .mosi_o(mo_o), .mosi_oe_o(mo_oe),
        .miso_i(mi_w), .miso_o(mi_o), .miso_oe_o(mi_oe), .ss_n_i(p_ss_n),
        .tx_watermark_i(txw), .rx_watermark_i(rxw),
        .tx_irq_o(txi), .rx_err_irq_o(rxi)
    );
    spidr_far far (
        .clk_i(clk), .sclk_i(sck_w), .mosi_i(mo_w), .miso_i(mi_w), .miso_o(p_mi),
        .sclk_o(p_sck), .mosi_o(p_mo), .ss_n_o(p_ss_n)
    );
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // request held until waitrequest is seen low before a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr_s <= w;
        rd_s <= ~w;
        do @(negedge clk); while (wrq !== 1'b0);
        @(posedge clk);
        q = rdo;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic chkr(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        chk(q & m, e);
    endtask
    task automatic poll(input int b);
        logic [31:0] q;
        for (int i = 0; i < 300; i++) begin
            bus(1'b0, OFS_CTRL, 32'h00000000, q);
            if (q[b] === 1'b1) break;
        end
    endtask
    function automatic logic [31:0] dflt(input int i);
        return (i == 0) ? 32'h00000100 : ((i == 1) ? {27'h0, SIZE_RST} : 32'h00000000);
    endfunction
    function automatic logic [31:0] irq_exp(input logic g, input logic e, input logic f,
                                            input logic wm);
        return {31'h0, g & e & (f | wm)};
    endfunction
    function automatic logic [31:0] rnd8();
        return {24'h000000, 8'($random(seed))};
    endfunction
    task automatic defaults;
        for (int i = 0; i < 4; i++) chkr(4'(4 * i), ALL_ONES, dflt(i));
        $display("test defaults done");
    endtask
    initial begin
        logic [31:0] a, b;
        rst <= 1'b1;
        adr <= 4'h0;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        wd <= 32'h00000000;
        txw <= 1'b0;
        rxw <= 1'b0;
        cyc(6);
        rst <= 1'b0;
        defaults();
        a = rnd8();
        wr(OFS_TXD, a);
        chkr(OFS_CTRL, 32'h00000100, 32'h00000100);
        chkr(OFS_TXD, ALL_ONES, a);
        $display("test disabled write done");
        b = rnd8();
        far.load(b[7:0]);
        wr(OFS_CTRL, 32'h0000003B);
        wr(OFS_TXD, a);
        poll(B_RXF);
        chk({31'h0, txi}, 32'h00000001);
        chk({31'h0, rxi}, 32'h00000001);
        chkr(OFS_CTRL, 32'h00000300, 32'h00000300);
        chk({24'h0, far.rx_q}, a);
        chkr(OFS_RXD, ALL_ONES, b);
        chkr(OFS_CTRL, 32'h00000200, 32'h00000000);
        chk({31'h0, rxi}, 32'h00000000);
        $display("test master word done");
        wr(OFS_CTRL, 32'h0000002B);
        far.load(b[7:0]);
        wr(OFS_TXD, rnd8());
        poll(B_RXF);
        far.load(a[7:0]);
        wr(OFS_TXD, rnd8());
        for (int i = 0; i < 600 && rxi !== 1'b1; i++) cyc(1);
        chk({31'h0, rxi}, 32'h00000001);
        chkr(OFS_RXD, ALL_ONES, b);
        chkr(OFS_CTRL, 32'h00000600, 32'h00000400);
        chkr(OFS_RXD, ALL_ONES, b);
        chkr(OFS_CTRL, 32'h00000600, 32'h00000000);
        $display("test overrun done");
        a = rnd8();
        b = rnd8();
        far.load(b[7:0]);
        wr(OFS_TXD, a);
        cyc(20);
        wr(OFS_CTRL, 32'h0000002A);
        poll(B_RXF);
        chkr(OFS_CTRL, 32'h00000200, 32'h00000200);
        chkr(OFS_RXD, ALL_ONES, b);
        chk({24'h0, far.rx_q}, a);
        chk({31'h0, sck_oe}, 32'h00000000);
        chkr(OFS_CTRL, 32'h0000113F, 32'h0000012A);
        chk({31'h0, txi}, 32'h00000000);
        $display("test master disable done");
        wr(OFS_CTRL, 32'h00000027);
        far.sel(1'b0);
        chkr(OFS_CTRL, 32'h00000807, 32'h00000806);
        chk({31'h0, rxi}, 32'h00000001);
        far.sel(1'b1);
        wr(OFS_CTRL, 32'h00000800);
        chkr(OFS_CTRL, 32'h00000800, 32'h00000000);
        chk({31'h0, rxi}, 32'h00000000);
        wr(OFS_CTRL, 32'h00000023);
        far.sel(1'b0);
        chkr(OFS_CTRL, 32'h00000801, 32'h00000001);
        far.sel(1'b1);
        $display("test select fault done");
        a = rnd8();
        wr(OFS_CTRL, 32'h00000001);
        far.sel(1'b0);
        far.shift(rnd8(), 3);
        chk({31'h0, mi_oe}, 32'h00000001);
        wr(OFS_CTRL, 32'h00000000);
        cyc(2);
        chk({31'h0, mi_oe}, 32'h00000000);
        far.sel(1'b1);
        chkr(OFS_CTRL, 32'h00000200, 32'h00000000);
        wr(OFS_CTRL, 32'h00000001);
        b = rnd8();
        wr(OFS_TXD, b);
        far.sel(1'b0);
        far.shift(a[7:0], 8);
        far.sel(1'b1);
        chkr(OFS_RXD, ALL_ONES, a);
        chk({24'h0, far.got_q}, b);
        $display("test slave abort done");
        b = rnd8();
        b = {27'h0, 1'b1, b[3:0]};
        wr(OFS_SIZE, b);
        wr(OFS_CTRL, 32'h00000019);
        wr(OFS_TXD, rnd8());
        chkr(OFS_CTRL, 32'h00000100, 32'h00000000);
        for (int i = 0; i < 4; i++) begin
            txw <= i[0];
            rxw <= i[1];
            cyc(2);
            chk({31'h0, txi}, irq_exp(1'b1, 1'b1, 1'b0, i[0]));
            chk({31'h0, rxi}, irq_exp(1'b1, 1'b1, 1'b0, i[1]));
        end
        $display("test watermark done");
        wr(OFS_CTRL, 32'h00000000);
        chkr(OFS_SIZE, ALL_ONES, b);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        defaults();
        tally_and_finish();
    end
endmodule // spi_disable_reset_and_irq_tb
